// file: dv/host_proc_model.sv
/*
 host_proc_model: processor side that drives the two power enables.
 assumes active-low reset and fault outputs from the sequencer.
*/
`timescale 1ns/1ns
module host_proc_model #(
   parameter int CD = 30
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic go,
   input  wire logic resetOutN,
   input  wire logic batteryFaultOutN,
   output logic      hvEn,
   output logic      lvEn,
   output logic      done
);
   int cnt;
   always_ff @(posedge clk) begin
      if (!nrst || !go || !resetOutN) begin
         hvEn <= 1'b0;
         lvEn <= 1'b0;
         done <= 1'b0;
         cnt  <= 0;
      end else if (!hvEn) begin
         hvEn <= batteryFaultOutN;
         cnt  <= 0;
      end else if (cnt < CD) begin
         cnt <= cnt + 1;
      end else if (!lvEn) begin
         lvEn <= 1'b1;
         cnt  <= 0;
      end else begin
         done <= 1'b1;
      end
   end
endmodule

// file: dv/tb_top.sv
/*
 tb_top: register, pin and sequencing checks of the reset sequencer.
 assumes shortened hold and step counts and a polling host model.
*/
`timescale 1ns/1ns
module tb_top import pmu_seq_pkg::*;;
   localparam int HOLD = 20;
   localparam int STEP = 4;
   localparam logic [11:0] A_PWR = {IDX_PWR_CTL, 2'b00};
   localparam logic [11:0] A_BAT = {IDX_BAT_CTL, 2'b00};
   localparam logic [11:0] A_PIN = {IDX_GPIO_CTL, 2'b00};
   localparam logic [11:0] A_STA = {IDX_STATUS, 2'b00};
   localparam logic [11:0] A_TMP = {IDX_THERM, 2'b00};
   logic        clk, nrst, go, done, resetInN, rtcStable, sysPowerOk;
   logic        highVoltagePowerEnable, lowVoltagePowerEnable, lvEn;
   logic        mainBatPresent, backupBatPresent, mainAboveHigh;
   logic        mainBelowLow, thermWarnSet, thermWarnClear, resetOutN;
   logic        batteryFaultOutN, wakeupOut, coreLogicEn, otherHvEn;
   logic        rtcFromMain, backupChargerEn, s_axi_awvalid, s_axi_awready;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, ext, pinIn, pinOut, pinOe;
   logic [2:0]  regulatingRaw;
   logic [5:0]  thermFlagsRaw;
   int          errorCnt, checkCount, cyc, n;
   // ------------------------------------------------------------
   // design, host and pads
   // ------------------------------------------------------------
   pmu_reset_seq #(.HOLD_CYCLES(HOLD), .STEP_CYCLES(STEP)) dut (
      .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .resetInN, .highVoltagePowerEnable,
      .lowVoltagePowerEnable, .rtcStable, .sysPowerOk, .mainBatPresent,
      .backupBatPresent, .mainAboveHigh, .mainBelowLow, .regulatingRaw,
      .thermFlagsRaw, .thermWarnSet, .thermWarnClear, .pinIn, .pinOut,
      .pinOe, .resetOutN, .batteryFaultOutN, .wakeupOut, .coreLogicEn,
      .otherHvEn, .lvEn, .rtcFromMain, .backupChargerEn);
   host_proc_model u_host (.clk, .nrst, .go, .resetOutN, .batteryFaultOutN,
      .hvEn(highVoltagePowerEnable), .lvEn(lowVoltagePowerEnable), .done);
   assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (errorCnt == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) ||
                 (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid) @(posedge clk);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, r);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   task automatic bat(input logic a, b, m, k, s, f);
      mainAboveHigh    <= a;
      mainBelowLow     <= b;
      mainBatPresent   <= m;
      backupBatPresent <= k;
      wt(5);
      chk(rtcFromMain, s);
      chk(batteryFaultOutN, f);
   endtask
   task automatic holdLen(input int start);
      n = start;
      while (!resetOutN) begin
         @(posedge clk);
         n++;
      end
   endtask
   // ------------------------------------------------------------
   // clock, timeout and sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errorCnt++;
         summarize();
      end
   end
   initial begin
      {nrst, go, rtcStable, sysPowerOk, mainBelowLow} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, thermWarnSet, thermWarnClear, thermFlagsRaw} = '0;
      {resetInN, mainBatPresent, backupBatPresent, mainAboveHigh} = '1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      regulatingRaw = 3'h7;
      ext = 2'h3;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rc(A_PWR, 32'h20, RESP_OKAY);
      rc(A_BAT, 32'h40, RESP_OKAY);
      rc(12'h100, 32'h0, RESP_SLVERR);
      wr(12'h100, 8'h5A, RESP_SLVERR);
      wr(A_PWR, 8'h10, RESP_OKAY);
      go <= 1'b1;
      rtcStable <= 1'b1;
      holdLen(0);
      chk(n > HOLD, 1);
      chk(coreLogicEn, 0);
      sysPowerOk <= 1'b1;
      while (!coreLogicEn) @(posedge clk);
      chk(batteryFaultOutN, 1);
      chk(otherHvEn, 0);
      holdLen(0);
      n = 0;
      while (!otherHvEn) begin
         @(posedge clk);
         n++;
      end
      chk(n, STEP + 1);
      while (!done) @(posedge clk);
      wt(2);
      chk(lvEn, 1);
      wr(A_STA, 8'hFF, RESP_OKAY);
      rc(A_STA, 32'h0F, RESP_OKAY);
      go <= 1'b0;
      wt(20);
      wr(A_PWR, 8'h12, RESP_OKAY);
      wt(5);
      chk(lvEn, 0);
      wr(A_PWR, 8'h16, RESP_OKAY);
      rc(A_PWR, 32'h16, RESP_OKAY);
      wt(5);
      chk(lvEn, 1);
      for (int m = 0; m < 4; m++) begin
         wr(A_PIN, 8'(m << 2), RESP_OKAY);
         wt(5);
         chk(pinOe[1], m[0]);
         chk(pinOe[1] & pinOut[1], m[0] & m[1]);
         rc(A_PIN, (m << 2) | (m == 2 ? 32'h20 : 0), RESP_OKAY);
      end
      ext[0] <= 1'b0;
      wr(A_PIN, 8'h03, RESP_OKAY);
      wt(5);
      chk(pinOe[0], 0);
      chk(backupChargerEn, 1);
      ext[0] <= 1'b1;
      wt(5);
      chk(backupChargerEn, 0);
      wr(A_BAT, 8'h60, RESP_OKAY);
      wt(5);
      chk(backupChargerEn, 1);
      wr(A_BAT, 8'h00, RESP_OKAY);
      wt(5);
      chk(pinOe[0] & pinOut[0], 1);
      chk(backupChargerEn, 0);
      wr(A_PIN, 8'h02, RESP_OKAY);
      wt(5);
      rc(A_PIN, 32'h12, RESP_OKAY);
      bat(0, 1, 1, 1, 0, 0);
      bat(0, 0, 1, 1, 0, 0);
      bat(1, 0, 1, 1, 1, 1);
      bat(0, 1, 1, 0, 1, 0);
      bat(0, 1, 0, 1, 0, 0);
      wr(A_BAT, 8'h80, RESP_OKAY);
      bat(0, 1, 1, 1, 1, 0);
      thermFlagsRaw <= 6'h2D;
      wr(A_TMP, 8'h01, RESP_OKAY);
      wt(5);
      rc(A_TMP, 32'h41, RESP_OKAY);
      wr(A_TMP, 8'h00, RESP_OKAY);
      wt(5);
      rc(A_TMP, 32'h00, RESP_OKAY);
      thermWarnSet <= 1'b1;
      wt(5);
      chk(wakeupOut, 1);
      thermWarnSet <= 1'b0;
      wt(5);
      chk(wakeupOut, 1);
      thermWarnClear <= 1'b1;
      wt(5);
      chk(wakeupOut, 0);
      resetInN <= 1'b0;
      wt(5);
      chk(resetOutN, 0);
      resetInN <= 1'b1;
      holdLen(5);
      chk(n > HOLD, 1);
      wr(A_PWR, 8'h01, RESP_OKAY);
      while (!coreLogicEn) @(posedge clk);
      chk(otherHvEn, 0);
      @(posedge clk);
      chk(otherHvEn, 1);
      summarize();
   end
endmodule

// file: hdl/pmu_reset_seq.sv
/*
 pmu_reset_seq: reset sequencing, regulator enable order, battery
 selection, general pin control and thermal flags, with AXI4-Lite
 registers. assumes comparator and pin inputs are asynchronous levels.
*/
// Operation
// - each general pin: input, output or high impedance
// - input pin level readable in a status bit
// - mode bits: 00 hiz, 10 in, 01/11 out
// - charger enable from pin or backup control
// - single present battery feeds rtc regulator
// - both present, charged main battery selected
// - switch below 2.9V, return above 3.1V
// - no backup battery bit keeps main selected
// - fault output warns while main battery discharges
// - per domain read only regulating ok bits
// - enable all flags gives temperature code
// - hysteretic over temperature flag on wakeup
// - cold start reset held at least 50 ms
// - fault released once input power present and main battery above high threshold
// - core regulator first, others after delay
// - low voltage enable from pin or bit
// - reset input restarts 50 ms reset sequence
// - delay field sets 0 to 1.5 ms spacing
// - low voltage needs high voltage unless bypassed
`timescale 1ns/1ns
module pmu_reset_seq import pmu_seq_pkg::*; #(
   parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
   parameter int STEP_CYCLES = DELAY_STEP_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        resetInN,
   input  wire logic        highVoltagePowerEnable,
   input  wire logic        lowVoltagePowerEnable,
   input  wire logic        rtcStable,
   input  wire logic        sysPowerOk,
   input  wire logic        mainBatPresent,
   input  wire logic        backupBatPresent,
   input  wire logic        mainAboveHigh,
   input  wire logic        mainBelowLow,
   input  wire logic [2:0]  regulatingRaw,
   input  wire logic [5:0]  thermFlagsRaw,
   input  wire logic        thermWarnSet,
   input  wire logic        thermWarnClear,
   input  wire logic [1:0]  pinIn,
   output logic [1:0]       pinOut,
   output logic [1:0]       pinOe,
   output logic             resetOutN,
   output logic             batteryFaultOutN,
   output logic             wakeupOut,
   output logic             coreLogicEn,
   output logic             otherHvEn,
   output logic             lvEn,
   output logic             rtcFromMain,
   output logic             backupChargerEn
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [10:0] decode(input logic [11:0] a);
      logic [10:0] r;
      r = 11'h000;
      if (a[1:0] == 2'h0) begin
         r = {1'b1, a[11:2]};
      end
      return r;
   endfunction

   function automatic logic [2:0] countOnes(input logic [5:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 6; i++) begin
         n = n + {2'h0, v[i]};
      end
      return n;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 26;
   logic [SW-1:0] syncIn;
   logic          sRstN, sHv, sLv, sRtc, sVin, sMain, sBack, sHigh, sLow;
   logic          sWarnSet, sWarnClr;
   logic [2:0]    sOk;
   logic [5:0]    sFlags;
   logic [1:0]    sPin;

   sync_two_flop #(.W(SW)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({~resetInN, highVoltagePowerEnable, lowVoltagePowerEnable,
              rtcStable, sysPowerOk, mainBatPresent, backupBatPresent,
              mainAboveHigh, mainBelowLow, thermWarnSet, thermWarnClear,
              regulatingRaw, thermFlagsRaw, pinIn, 4'h0}),
      .q    (syncIn)
   );

   assign sRstN    = ~syncIn[25];
   assign sHv      = syncIn[24];
   assign sLv      = syncIn[23];
   assign sRtc     = syncIn[22];
   assign sVin     = syncIn[21];
   assign sMain    = syncIn[20];
   assign sBack    = syncIn[19];
   assign sHigh    = syncIn[18];
   assign sLow     = syncIn[17];
   assign sWarnSet = syncIn[16];
   assign sWarnClr = syncIn[15];
   assign sOk      = syncIn[14:12];
   assign sFlags   = syncIn[11:6];
   assign sPin     = syncIn[5:4];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   state_s st, next_st;
   logic [CNT_W-1:0] holdLast, dlyTarget;
   logic             hvEff, lvReq, wrDo, no_backup_battery_bit, chgSel;
   logic [10:0]      wSel, rSel;
   logic [1:0]       mode [2];

   assign holdLast  = CNT_W'(HOLD_CYCLES - 1);
   assign dlyTarget = CNT_W'(STEP_CYCLES * int'(st.pwrCtl[PWR_DLY_LSB+:2]));
   assign no_backup_battery_bit      = st.batCtl[BAT_NO_BACKUP_BATTERY_BIT];
   assign chgSel    = st.batCtl[BAT_CHG_SEL];
   assign mode[0]   = st.gpioCtl[1:0];
   assign mode[1]   = st.gpioCtl[3:2];

   always_comb begin
      next_st = st;
      hvEff   = 1'b0;
      lvReq   = 1'b0;
      wrDo    = 1'b0;
      wSel    = decode(st.awAddr);
      rSel    = decode(s_axi_araddr);

      // reset sequence
      case (st.seq)
         SEQ_COLD: begin
            if (sRtc) begin
               next_st.seq     = SEQ_HOLD;
               next_st.holdCnt = '0;
            end
         end
         SEQ_HOLD: begin
            if (st.holdCnt >= holdLast) begin
               next_st.seq = SEQ_RUN;
            end else begin
               next_st.holdCnt = st.holdCnt + CNT_W'(1);
            end
         end
         SEQ_RUN: begin
            hvEff = sHv | st.pwrCtl[PWR_SW_HV];
         end
         default: next_st.seq = SEQ_COLD;
      endcase
      if (!sRstN && st.seq != SEQ_COLD) begin
         next_st.seq     = SEQ_HOLD;
         next_st.holdCnt = '0;
         next_st.pwrCtl[PWR_SW_HV] = 1'b0;
         next_st.pwrCtl[PWR_SW_LV] = 1'b0;
      end
      next_st.resetOutN = (next_st.seq == SEQ_RUN);

      // high voltage order, core first on, last off
      if (hvEff) begin
         next_st.coreLogicEn = 1'b1;
         if (!st.otherHvEn && st.coreLogicEn) begin
            if (st.dlyCnt >= dlyTarget) begin
               next_st.otherHvEn = 1'b1;
               next_st.dlyCnt    = '0;
            end else begin
               next_st.dlyCnt = st.dlyCnt + CNT_W'(1);
            end
         end
      end else begin
         next_st.otherHvEn = 1'b0;
         if (st.coreLogicEn && !st.otherHvEn) begin
            if (st.dlyCnt >= dlyTarget) begin
               next_st.coreLogicEn = 1'b0;
               next_st.dlyCnt      = '0;
            end else begin
               next_st.dlyCnt = st.dlyCnt + CNT_W'(1);
            end
         end
      end

      // low voltage enable
      lvReq = sLv | st.pwrCtl[PWR_SW_LV];
      next_st.lvEn = (st.seq == SEQ_RUN) && lvReq
                     && (hvEff || st.pwrCtl[PWR_BYPASS]);

      // regulating status per enabled domain
      next_st.okBits = sOk & {st.lvEn, st.otherHvEn, st.coreLogicEn};

      // battery selection with hysteresis
      if (no_backup_battery_bit) begin
         next_st.rtcFromMain = 1'b1;
      end else if (sMain && !sBack) begin
         next_st.rtcFromMain = 1'b1;
      end else if (!sMain && sBack) begin
         next_st.rtcFromMain = 1'b0;
      end else if (sLow) begin
         next_st.rtcFromMain = 1'b0;
      end else if (sHigh) begin
         next_st.rtcFromMain = 1'b1;
      end
      next_st.batteryFaultOutN = sVin && sMain && sHigh;

      // general pins
      for (int p = 0; p < 2; p++) begin
         next_st.pinOe[p]    = mode[p][0];
         next_st.pinOut[p]   = mode[p][1] & mode[p][0];
         next_st.readback[p] = (mode[p] == PIN_INPUT) & sPin[p];
      end
      if (chgSel) begin
         next_st.pinOe[0]    = 1'b0;
         next_st.pinOut[0]   = 1'b0;
         next_st.readback[0] = 1'b0;
      end
      next_st.backupChargerEn = st.batCtl[BAT_BU_CHG]
                                | (chgSel & ~sPin[0]);

      // thermal flags
      next_st.tempCode = st.enAllFlags ? countOnes(sFlags) : 3'h0;
      if (sWarnSet) begin
         next_st.wakeupOut = 1'b1;
      end else if (sWarnClr) begin
         next_st.wakeupOut = 1'b0;
      end

      // write channel
      if (s_axi_awvalid && st.awready) begin
         next_st.awGot  = 1'b1;
         next_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.wGot  = 1'b1;
         next_st.wData = s_axi_wdata[7:0];
         next_st.wLane = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.awGot && st.wGot && !st.bvalid) begin
         wrDo           = 1'b1;
         next_st.awGot  = 1'b0;
         next_st.wGot   = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = RESP_OKAY;
         case (wSel)
            {1'b1, IDX_PWR_CTL}: begin
               if (st.wLane) begin
                  next_st.pwrCtl = st.wData & PWR_CTL_MASK;
               end
            end
            {1'b1, IDX_BAT_CTL}: begin
               if (st.wLane) begin
                  next_st.batCtl = st.wData & BAT_CTL_MASK;
               end
            end
            {1'b1, IDX_GPIO_CTL}: begin
               if (st.wLane) begin
                  next_st.gpioCtl = st.wData[3:0];
               end
            end
            {1'b1, IDX_THERM}: begin
               if (st.wLane) begin
                  next_st.enAllFlags = st.wData[0];
               end
            end
            {1'b1, IDX_STATUS}: next_st.bresp = RESP_OKAY;
            default: next_st.bresp = RESP_SLVERR;
         endcase
      end

      // read channel
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         next_st.rdata  = 32'h0000_0000;
         case (rSel)
            {1'b1, IDX_PWR_CTL}:  next_st.rdata[7:0] = st.pwrCtl;
            {1'b1, IDX_BAT_CTL}:  next_st.rdata[7:0] = st.batCtl;
            {1'b1, IDX_GPIO_CTL}: next_st.rdata[7:0] =
               {2'h0, st.readback, st.gpioCtl};
            {1'b1, IDX_STATUS}:   next_st.rdata[7:0] =
               {1'b0, st.backupChargerEn, st.wakeupOut,
                ~st.batteryFaultOutN, st.rtcFromMain, st.okBits};
            {1'b1, IDX_THERM}:    next_st.rdata[7:0] =
               {1'b0, st.tempCode, 3'h0, st.enAllFlags};
            default: next_st.rresp = RESP_SLVERR;
         endcase
      end
      next_st.awready = !next_st.awGot && !next_st.bvalid;
      next_st.wready  = !next_st.wGot && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st         <= '0;
         st.seq     <= SEQ_COLD;
         st.pwrCtl  <= PWR_CTL_RST;
         st.batCtl  <= BAT_CTL_RST;
         st.rtcFromMain <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_awready    = st.awready;
   assign s_axi_wready     = st.wready;
   assign s_axi_bvalid     = st.bvalid;
   assign s_axi_bresp      = st.bresp;
   assign s_axi_arready    = st.arready;
   assign s_axi_rvalid     = st.rvalid;
   assign s_axi_rresp      = st.rresp;
   assign s_axi_rdata      = st.rdata;
   assign pinOut           = st.pinOut;
   assign pinOe            = st.pinOe;
   assign resetOutN        = st.resetOutN;
   assign batteryFaultOutN = st.batteryFaultOutN;
   assign wakeupOut        = st.wakeupOut;
   assign coreLogicEn      = st.coreLogicEn;
   assign otherHvEn        = st.otherHvEn;
   assign lvEn             = st.lvEn;
   assign rtcFromMain      = st.rtcFromMain;
   assign backupChargerEn  = st.backupChargerEn;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   reset_hold_a: assert property ($rose(resetOutN) |->
      $past(st.holdCnt) == holdLast) else $error("reset released early");
   hw_reset_a: assert property (!sRstN && st.seq == SEQ_RUN
      |=> !resetOutN ##1 !resetOutN) else $error("reset input ignored");
   core_first_a: assert property (otherHvEn |-> coreLogicEn)
      else $error("supply on before core regulator");
   delay_zero_a: assert property ($rose(coreLogicEn)
      && st.pwrCtl[PWR_DLY_LSB+:2] == 2'h0 && hvEff |=> otherHvEn)
      else $error("zero delay not honoured");
   lv_depend_a: assert property ($rose(lvEn) |->
      $past(hvEff || st.pwrCtl[PWR_BYPASS])) else $error("lv without hv");
   no_backup_battery_bit_main_a: assert property (no_backup_battery_bit |=> rtcFromMain)
      else $error("switched with no backup battery");
   bat_return_a: assert property ($rose(rtcFromMain) && !$past(no_backup_battery_bit)
      |-> $past(sHigh || !sBack)) else $error("returned below threshold");
   fault_free_a: assert property (batteryFaultOutN
      |-> $past(sVin && sHigh)) else $error("fault released early");
   pin_mode_a: assert property (!$past(chgSel) |->
      pinOe[0] == $past(mode[0][0]) && pinOut[0] == ($past(mode[0]) == 2'h3))
      else $error("pin mode mismatch");
   charger_a: assert property ($past(nrst) |->
      backupChargerEn == $past(st.batCtl[BAT_BU_CHG] | (chgSel & ~sPin[0])))
      else $error("charger enable wrong");
   wake_flag_a: assert property (sWarnSet |=> wakeupOut)
      else $error("warning not on wakeup");

   seq_done_c: cover property ($rose(resetOutN));
   supply_up_c: cover property ($rose(otherHvEn) ##[1:100] lvEn);
   to_backup_c: cover property ($fell(rtcFromMain));
   write_c: cover property (wrDo && st.bresp == RESP_OKAY);

endmodule

// file: hdl/pmu_seq_pkg.sv
/*
 pmu_seq_pkg: constants, register indices, reset values and the state
 carrier of the reset sequencer and pin control block.
 assumes a 25 MHz clock and AXI4-Lite register access.
*/
package pmu_seq_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 40;
   localparam int RESET_HOLD_MS  = 50;
   localparam int DELAY_STEP_US  = 500;
   localparam int RESET_HOLD_CYCLES =
      (RESET_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_STEP_CYCLES =
      (DELAY_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 21;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_PWR_CTL  = 10'h080;
   localparam logic [9:0] IDX_BAT_CTL  = 10'h089;
   localparam logic [9:0] IDX_GPIO_CTL = 10'h08A;
   localparam logic [9:0] IDX_STATUS   = 10'h08B;
   localparam logic [9:0] IDX_THERM    = 10'h08C;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int PWR_SW_HV   = 0;
   localparam int PWR_SW_LV   = 1;
   localparam int PWR_BYPASS  = 2;
   localparam int PWR_DLY_LSB = 4;
   localparam int BAT_NO_BACKUP_BATTERY_BIT    = 7;
   localparam int BAT_CHG_SEL = 6;
   localparam int BAT_BU_CHG  = 5;
   localparam int GPIO_RB_LSB = 4;
   localparam int THERM_CODE_LSB = 4;
   localparam logic [7:0] PWR_CTL_RST  = 8'h20;
   localparam logic [7:0] BAT_CTL_RST  = 8'h40;
   localparam logic [7:0] PWR_CTL_MASK = 8'h37;
   localparam logic [7:0] BAT_CTL_MASK = 8'hE0;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // ----------------------------------------------------------------
   // pin modes and sequencer states
   // ----------------------------------------------------------------
   localparam logic [1:0] PIN_HIZ   = 2'h0;
   localparam logic [1:0] PIN_INPUT = 2'h2;

   typedef enum logic [2:0] {
      SEQ_COLD = 3'h1,
      SEQ_HOLD = 3'h2,
      SEQ_RUN  = 3'h4
   } seq_e;

   typedef struct packed {
      seq_e             seq;
      logic [CNT_W-1:0] holdCnt;
      logic [CNT_W-1:0] dlyCnt;
      logic             resetOutN;
      logic             batteryFaultOutN;
      logic             wakeupOut;
      logic             coreLogicEn;
      logic             otherHvEn;
      logic             lvEn;
      logic             rtcFromMain;
      logic             backupChargerEn;
      logic [1:0]       pinOut;
      logic [1:0]       pinOe;
      logic [1:0]       readback;
      logic [2:0]       okBits;
      logic [2:0]       tempCode;
      logic [7:0]       pwrCtl;
      logic [7:0]       batCtl;
      logic [3:0]       gpioCtl;
      logic             enAllFlags;
      logic             awGot;
      logic             wGot;
      logic [11:0]      awAddr;
      logic [7:0]       wData;
      logic             wLane;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
   } state_s;

endpackage

// file: hdl/sync_two_flop.sv
/*
 sync_two_flop: two flip-flop level synchroniser, one bit per lane.
 assumes inputs are levels from outside the clock domain.
*/
`timescale 1ns/1ns
module sync_two_flop #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] stage;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stage <= '0;
         q     <= '0;
      end else begin
         stage <= d;
         q     <= stage;
      end
   end

endmodule
